//--- src/toc_pkg.sv
// Package: register map, field layout, reset values and modes of the timer/capture block
package toc_pkg;
    localparam logic [7:0] ADDR_TIMER_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_CAPTURE_CONTROL = 8'h04;
    localparam logic [7:0] ADDR_CAPTURE_RESULT = 8'h08;
    localparam logic [7:0] ADDR_TIMER_COUNT = 8'h0C;
    localparam logic [7:0] ADDR_FLAG = 8'h10;
    localparam logic [7:0] ADDR_ENABLE = 8'h14;
    localparam logic [7:0] ADDR_PORT_DATA = 8'h18;
    localparam logic [7:0] ADDR_PORT_DIR = 8'h1C;
    localparam logic [7:0] ADDR_PIN_SOURCE = 8'h20;
    // Timer control bit positions
    localparam int TC_RUN = 0;
    localparam int TC_CLK_SEL = 1;
    localparam int TC_OSC_EN = 3;
    // Flag and enable bit position
    localparam int CAPTURE_FLAG_BIT = 2;
    // Pin source register bit positions
    localparam int PS_FW_CLK = 0;
    localparam int PS_SELECT = 2;
    // Port bit positions
    localparam int PIN_CLK = 1;
    localparam int PIN_XTAL = 2;
    localparam int PIN_CAP = 3;
    // Reset values
    localparam logic [7:0] TIMER_CONTROL_RESET = 8'h00;
    localparam logic [3:0] CAPTURE_MODE_RESET = 4'h0;
    localparam logic [3:0] PORT_DIR_RESET = 4'hF;
    // Capture mode field codes
    localparam logic [3:0] CAP_FALL = 4'h4;
    localparam logic [3:0] CAP_RISE = 4'h5;
    localparam logic [3:0] CAP_RISE4 = 4'h6;
    localparam logic [3:0] CAP_RISE16 = 4'h7;
    localparam logic [3:0] PRESCALE_4_LAST = 4'h3;
    localparam logic [3:0] PRESCALE_16_LAST = 4'hF;
    localparam int SYNC_STAGES = 2;
    typedef enum logic [1:0] {
        TOC_SRC_OFF,
        TOC_SRC_INTERNAL,
        TOC_SRC_PIN,
        TOC_SRC_CRYSTAL
    } toc_src_t;
endpackage

//--- src/toc_cap_if.sv
// Interface: capture request and result between the capture unit and the main block
`timescale 1ns/1ps
interface toc_cap_if;
    logic [3:0] mode;
    logic level;
    logic [15:0] count;
    logic [15:0] result;
    logic event_pulse;
    modport unit (input mode, input level, input count, output result, output event_pulse);
    modport core (output mode, output level, output count, input result, input event_pulse);
endinterface

//--- src/toc_sync.sv
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ps
module toc_sync #(
    parameter int WIDTH = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage_one;

    if (WIDTH < 1) begin : g_width_check
        $error("toc_sync width must be at least 1");
    end

    // First stage feeds only the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage_one <= '0;
            sync_out <= '0;
        end else begin
            stage_one <= async_in;
            sync_out <= stage_one;
        end
    end
endmodule

//--- src/toc_capture.sv
// Capture unit: edge detection, event prescaler and result latch
`timescale 1ns/1ps
module toc_capture (
    input wire logic pclk,
    input wire logic presetn,
    toc_cap_if.unit cap
);
    logic level_d;
    logic [3:0] prescale;
    logic rise;
    logic fall;
    logic in_capture;
    logic fire;

    assign in_capture = (cap.mode == toc_pkg::CAP_FALL) || (cap.mode == toc_pkg::CAP_RISE)
        || (cap.mode == toc_pkg::CAP_RISE4) || (cap.mode == toc_pkg::CAP_RISE16);
    assign rise = cap.level && !level_d;
    assign fall = !cap.level && level_d;

    always_comb begin
        fire = 1'b0;
        unique case (cap.mode)
            toc_pkg::CAP_FALL: fire = fall;
            toc_pkg::CAP_RISE: fire = rise;
            toc_pkg::CAP_RISE4: fire = rise && (prescale[1:0] == toc_pkg::PRESCALE_4_LAST[1:0]);
            toc_pkg::CAP_RISE16: fire = rise && (prescale == toc_pkg::PRESCALE_16_LAST);
            default: fire = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_d <= 1'b0;
        end else begin
            level_d <= cap.level;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prescale <= '0;
        end else if (!in_capture) begin
            prescale <= '0;
        end else if (rise) begin
            prescale <= prescale + 4'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap.result <= 16'h0000;
        end else if (fire) begin
            cap.result <= cap.count;
        end
    end

    assign cap.event_pulse = fire;
endmodule

//--- src/toc_top.sv
// Timer one clock-source selector, shared-pin control and capture unit with APB registers
//
// Chosen here: the address map and register access over APB.
`timescale 1ns/1ps
// Operation
// - Control pattern off stops timer; shared pins plain I/O
// - Timer mode counts every instruction clock
// - Pin-source counter mode counts external pin clock; status shows pin level
// - Firmware clock bit drives clock pin and makes timer clock
// - External counter: clock port bit reads 0 input, latch output, writes latch only
// - Crystal mode: two pins form oscillator; firmware bit reads 0, unwritable
// - Crystal mode: both bits read 0/latch; pins driven from latch after leaving
// - Run bit starts or stops timer in every source mode
// - Capture copies full 16-bit timer into result pair
// - Mode field picks falling, rising, every fourth or sixteenth rising edge
// - Each capture sets flag bit 2; software clears it
// - New capture overwrites unread result
// - Capture pin as output: data write can trigger capture
// - Mode change may set flag falsely; software masks then clears
// - Prescaler clears when off, non-capture mode or reset
// - Direct prescale switch keeps count and may raise flag
module toc_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:1] port_b_pins_in,
    output logic [3:1] port_b_pins_out,
    output logic [3:1] port_b_pins_oe,
    input wire logic crystal_clock,
    output logic crystal_osc_active,
    output logic capture_irq
);
    logic [7:0] timer_one_control;
    logic [3:0] capture_mode_field;
    logic [15:0] timer_one_count;
    logic capture_irq_flag;
    logic capture_irq_enable;
    logic [3:1] port_latch;
    logic [3:1] port_dir;
    logic pin_source_select;
    logic firmware_clock_bit;
    logic [4:1] pins_sync;
    logic [4:1] pins_async;
    logic clk_level_d;
    logic tick;
    logic tick_src;
    logic wr;
    logic rd;
    logic known;
    logic ext_mode;
    logic xtal_mode;
    logic [3:1] pin_read;
    logic [31:0] next_rdata;
    toc_pkg::toc_src_t src;
    toc_cap_if cap ();

    assign wr = psel && penable && pwrite;
    // Read data fetched in setup so it stands at the access edge
    assign rd = psel && !penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !known;

    always_comb begin
        if (!timer_one_control[toc_pkg::TC_CLK_SEL]) begin
            src = timer_one_control[toc_pkg::TC_RUN] ? toc_pkg::TOC_SRC_INTERNAL
                : toc_pkg::TOC_SRC_OFF;
        end else if (timer_one_control[toc_pkg::TC_OSC_EN]) begin
            src = toc_pkg::TOC_SRC_CRYSTAL;
        end else begin
            src = toc_pkg::TOC_SRC_PIN;
        end
    end
    assign ext_mode = timer_one_control[toc_pkg::TC_CLK_SEL];
    assign xtal_mode = ext_mode && timer_one_control[toc_pkg::TC_OSC_EN];
    assign crystal_osc_active = xtal_mode;

    // Pins and crystal clock are foreign to pclk: two flops first
    assign pins_async = {crystal_clock, port_b_pins_in};
    toc_sync #(.WIDTH(4)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(pins_async),
        .sync_out(pins_sync)
    );

    always_comb begin
        unique case (src)
            toc_pkg::TOC_SRC_PIN: tick_src = pin_source_select ? pins_sync[1] : firmware_clock_bit;
            toc_pkg::TOC_SRC_CRYSTAL: tick_src = pins_sync[4];
            default: tick_src = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_level_d <= 1'b0;
        end else begin
            clk_level_d <= tick_src;
        end
    end

    // run bit gates all sources
    // Outside sources count synced rising edges; very fast pins lose counts
    always_comb begin
        tick = 1'b0;
        if (timer_one_control[toc_pkg::TC_RUN]) begin
            unique case (src)
                toc_pkg::TOC_SRC_INTERNAL: tick = 1'b1;
                toc_pkg::TOC_SRC_PIN: tick = tick_src && !clk_level_d;
                toc_pkg::TOC_SRC_CRYSTAL: tick = tick_src && !clk_level_d;
                default: tick = 1'b0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_one_count <= 16'h0000;
        end else if (wr && paddr == toc_pkg::ADDR_TIMER_COUNT) begin
            timer_one_count <= pwdata[15:0];
        end else if (tick) begin
            timer_one_count <= timer_one_count + 16'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_one_control <= toc_pkg::TIMER_CONTROL_RESET;
        end else if (wr && paddr == toc_pkg::ADDR_TIMER_CONTROL) begin
            timer_one_control <= pwdata[7:0];
        end
    end

    // writing the off code here also clears the prescaler
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capture_mode_field <= toc_pkg::CAPTURE_MODE_RESET;
        end else if (wr && paddr == toc_pkg::ADDR_CAPTURE_CONTROL) begin
            capture_mode_field <= pwdata[3:0];
        end
    end

    // enable lets software mask false flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capture_irq_enable <= 1'b0;
        end else if (wr && paddr == toc_pkg::ADDR_ENABLE) begin
            capture_irq_enable <= pwdata[toc_pkg::CAPTURE_FLAG_BIT];
        end
    end

    // Direction 1 is input, so pins float safely after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_dir <= toc_pkg::PORT_DIR_RESET[3:1];
        end else if (wr && paddr == toc_pkg::ADDR_PORT_DIR) begin
            port_dir <= pwdata[3:1];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_source_select <= 1'b0;
        end else if (wr && paddr == toc_pkg::ADDR_PIN_SOURCE) begin
            pin_source_select <= pwdata[toc_pkg::PS_SELECT];
        end
    end

    // latch write may toggle the capture pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_latch <= 3'h0;
        end else if (wr && paddr == toc_pkg::ADDR_PORT_DATA) begin
            port_latch <= pwdata[3:1];
        end
    end

    // firmware bit unwritable in crystal mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            firmware_clock_bit <= 1'b0;
        end else if (wr && paddr == toc_pkg::ADDR_PIN_SOURCE && !xtal_mode) begin
            firmware_clock_bit <= pwdata[toc_pkg::PS_FW_CLK];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capture_irq_flag <= 1'b0;
        end else if (cap.event_pulse) begin
            capture_irq_flag <= 1'b1;
        end else if (wr && paddr == toc_pkg::ADDR_FLAG) begin
            capture_irq_flag <= pwdata[toc_pkg::CAPTURE_FLAG_BIT];
        end
    end
    assign capture_irq = capture_irq_flag && capture_irq_enable;

    // pins driven from latch once modes clear
    always_comb begin
        port_b_pins_oe = ~port_dir;
        port_b_pins_out = port_latch;
        if (ext_mode) begin
            port_b_pins_oe[toc_pkg::PIN_CLK] = !pin_source_select && !xtal_mode;
            port_b_pins_out[toc_pkg::PIN_CLK] = firmware_clock_bit;
        end
        if (xtal_mode) begin
            port_b_pins_oe[toc_pkg::PIN_XTAL] = 1'b0;
        end
    end

    // clock port bit reads 0 or latch
    always_comb begin
        pin_read = pins_sync[3:1];
        if (ext_mode) begin
            pin_read[toc_pkg::PIN_CLK] = port_dir[toc_pkg::PIN_CLK] ? 1'b0
                : port_latch[toc_pkg::PIN_CLK];
        end
        if (xtal_mode) begin
            pin_read[toc_pkg::PIN_XTAL] = port_dir[toc_pkg::PIN_XTAL] ? 1'b0
                : port_latch[toc_pkg::PIN_XTAL];
        end
    end

    // capture pin from synchroniser; output latch loops back
    assign cap.level = port_dir[toc_pkg::PIN_CAP] ? pins_sync[3] : port_latch[toc_pkg::PIN_CAP];
    assign cap.mode = capture_mode_field;
    assign cap.count = timer_one_count;
    toc_capture u_capture (
        .pclk(pclk),
        .presetn(presetn),
        .cap(cap)
    );

    always_comb begin
        known = 1'b1;
        next_rdata = 32'h0000_0000;
        unique case (paddr)
            toc_pkg::ADDR_TIMER_CONTROL: next_rdata[7:0] = timer_one_control;
            toc_pkg::ADDR_CAPTURE_CONTROL: next_rdata[3:0] = capture_mode_field;
            toc_pkg::ADDR_CAPTURE_RESULT: next_rdata[15:0] = cap.result;
            toc_pkg::ADDR_TIMER_COUNT: next_rdata[15:0] = timer_one_count;
            toc_pkg::ADDR_FLAG: next_rdata[toc_pkg::CAPTURE_FLAG_BIT] = capture_irq_flag;
            toc_pkg::ADDR_ENABLE: next_rdata[toc_pkg::CAPTURE_FLAG_BIT] = capture_irq_enable;
            toc_pkg::ADDR_PORT_DATA: next_rdata[3:1] = pin_read;
            toc_pkg::ADDR_PORT_DIR: next_rdata[3:1] = port_dir;
            // status shows clock pin; reads 0 in crystal mode
            toc_pkg::ADDR_PIN_SOURCE: begin
                next_rdata[toc_pkg::PS_SELECT] = pin_source_select;
                next_rdata[toc_pkg::PS_FW_CLK] = xtal_mode ? 1'b0
                    : (pin_source_select ? pins_sync[1] : firmware_clock_bit);
            end
            default: known = 1'b0;
        endcase
    end

    // Read data registered so the bus sees a flop output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd) begin
            prdata <= next_rdata;
        end
    end
endmodule

//--- sim/toc_top_props.sv
// Checker: port-level properties of the timer/capture block
`timescale 1ns/1ps
module toc_top_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [3:1] port_b_pins_oe,
    input wire logic [3:1] port_b_pins_out,
    input wire logic crystal_osc_active,
    input wire logic capture_irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic acc;
    logic wr;
    logic irq_wr;
    logic [3:2] wd;
    assign acc = psel && penable;
    assign wr = acc && pwrite;
    assign irq_wr = wr && (paddr == toc_pkg::ADDR_FLAG || paddr == toc_pkg::ADDR_ENABLE);
    assign wd = pwdata[3:2];
    a_ready_high: assert property (acc |-> pready)
        else $error("pready low in access phase");
    a_unmapped_err: assert property (acc && paddr > 8'h20 |-> pslverr)
        else $error("no error on unmapped address");
    a_mapped_ok: assert property (acc && paddr <= 8'h20 && paddr[1:0] == 2'b00 |-> !pslverr)
        else $error("error on mapped address");
    a_unmapped_zero: assert property (acc && !pwrite && paddr > 8'h20 |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_osc_on: assert property (
        wr && paddr == toc_pkg::ADDR_TIMER_CONTROL && pwdata[3] && pwdata[1] |=> crystal_osc_active)
        else $error("crystal mode not entered");
    a_osc_off: assert property (
        wr && paddr == toc_pkg::ADDR_TIMER_CONTROL && !pwdata[1] |=> !crystal_osc_active)
        else $error("crystal mode not left");
    a_dir_drives: assert property (
        wr && paddr == toc_pkg::ADDR_PORT_DIR && !crystal_osc_active
        |=> port_b_pins_oe[3:2] == ~$past(wd))
        else $error("direction not applied to pins");
    a_latch_out: assert property (
        wr && paddr == toc_pkg::ADDR_PORT_DATA && !crystal_osc_active
        |=> (port_b_pins_out[3:2] & port_b_pins_oe[3:2]) == ($past(wd) & port_b_pins_oe[3:2]))
        else $error("driven pin differs from latch");
    a_irq_mask: assert property (
        wr && paddr == toc_pkg::ADDR_ENABLE && !pwdata[2] |=> !capture_irq)
        else $error("interrupt not masked");
    a_irq_sw_clear: assert property ($fell(capture_irq) |-> $past(irq_wr))
        else $error("interrupt dropped without software write");
endmodule
bind toc_top toc_top_props toc_top_props_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .port_b_pins_oe(port_b_pins_oe),
    .port_b_pins_out(port_b_pins_out), .crystal_osc_active(crystal_osc_active),
    .capture_irq(capture_irq));

//--- sim/toc_pin_partner.sv
// Far-side model: external clock source, crystal and capture input pin
`timescale 1ns/1ps
module toc_pin_partner (
    input wire logic pclk,
    input wire logic [3:1] pin_out,
    input wire logic [3:1] pin_oe,
    input wire logic osc_active,
    input wire logic xtal_en,
    input wire logic ext_en,
    input wire logic ext_level,
    input wire logic cap_level,
    output logic [3:1] pin_in,
    output logic crystal_clock,
    output int xtal_edges
);
    logic noise = 1'b0;
    // Released pin 2, and pin 1 without ext_en, toggle each cycle so a stale level cannot pass; pin 3 follows cap_level
    always @(posedge pclk) noise <= ~noise;
    assign pin_in[1] = pin_oe[1] ? pin_out[1] : (ext_en ? ext_level : noise);
    assign pin_in[2] = pin_oe[2] ? pin_out[2] : noise;
    assign pin_in[3] = pin_oe[3] ? pin_out[3] : cap_level;
    // Crystal swings only while enabled; period well above pclk
    initial begin
        crystal_clock = 1'b0;
        xtal_edges = 0;
        forever begin
            #17;
            if (osc_active && xtal_en) begin
                crystal_clock = ~crystal_clock;
                if (crystal_clock) xtal_edges++;
            end else begin
                crystal_clock = 1'b0;
            end
        end
    end
endmodule

//--- sim/timer_one_clock_and_capture_tb.sv
// Testbench: register, shared-pin and capture checks of the timer block
`timescale 1ns/1ps
module timer_one_clock_and_capture_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic osc, irq, xclk, ext_en, ext_level, cap_level, xtal_en;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, prev;
    logic [3:1] pin_in, pin_out, pin_oe;
    logic [3:0] mode;
    logic [15:0] v;
    int failures, n_tests, xe, n;
    toc_top toc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .port_b_pins_in(pin_in),
        .port_b_pins_out(pin_out), .port_b_pins_oe(pin_oe), .crystal_clock(xclk),
        .crystal_osc_active(osc), .capture_irq(irq));
    toc_pin_partner toc_pin_partner_inst (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe),
        .osc_active(osc), .xtal_en(xtal_en), .ext_en(ext_en), .ext_level(ext_level),
        .cap_level(cap_level), .pin_in(pin_in), .crystal_clock(xclk), .xtal_edges(xe));
    task automatic finish_test();
        if (failures == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge pclk);
    endtask
    // Setup, access until pready, then one idle cycle
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        i = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (pready !== 1'b1) begin
            failures++;
            finish_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdr(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic pulse(input logic idle);
        cap_level <= !idle;
        cyc(6);
        cap_level <= idle;
        cyc(6);
    endtask
    function automatic int edges_needed(input logic [3:0] m);
        return (m == toc_pkg::CAP_RISE4) ? 4 : (m == toc_pkg::CAP_RISE16) ? 16 : 1;
    endfunction
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    initial begin
        {presetn, psel, penable, pwrite, ext_en, ext_level, cap_level, xtal_en} = 8'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        failures = 0;
        n_tests = 0;
        void'($urandom(86160));
        cyc(16);
        presetn <= 1'b1;
        cyc(1);
        chk({29'h0, pin_oe}, 32'h0);
        rdr(8'h24);
        chk({rd[30:0], err}, 32'h1);
        v = $urandom;
        wr(toc_pkg::ADDR_TIMER_COUNT, {16'h0, v});
        cyc(20);
        rdr(toc_pkg::ADDR_TIMER_COUNT);
        chk(rd, {16'h0, v});
        for (int r = 1; r >= 0; r--) begin
            wr(toc_pkg::ADDR_TIMER_CONTROL, r);
            rdr(toc_pkg::ADDR_TIMER_COUNT);
            prev = rd;
            rdr(toc_pkg::ADDR_TIMER_COUNT);
            chk({16'h0, rd[15:0] - prev[15:0]}, 3 * r);
        end
        ext_en <= 1'b1;
        wr(toc_pkg::ADDR_PIN_SOURCE, 32'h4);
        for (int r = 1; r >= 0; r--) begin
            wr(toc_pkg::ADDR_TIMER_COUNT, 0);
            wr(toc_pkg::ADDR_TIMER_CONTROL, 2 + r);
            n = 2 + $urandom % 8;
            repeat (n) pulse_ext();
            rdr(toc_pkg::ADDR_TIMER_COUNT);
            chk(rd, n * r);
        end
        ext_level <= 1'b1;
        cyc(4);
        rdr(toc_pkg::ADDR_PIN_SOURCE);
        chk(rd[0], 1);
        rdr(toc_pkg::ADDR_PORT_DATA);
        chk(rd[1], 0);
        ext_level <= 1'b0;
        wr(toc_pkg::ADDR_PORT_DATA, 32'h2);
        wr(toc_pkg::ADDR_PORT_DIR, 32'hC);
        rdr(toc_pkg::ADDR_PORT_DATA);
        chk(rd[1], 1);
        wr(toc_pkg::ADDR_PORT_DIR, 32'hE);
        ext_en <= 1'b0;
        wr(toc_pkg::ADDR_PIN_SOURCE, 0);
        wr(toc_pkg::ADDR_TIMER_CONTROL, 32'h3);
        wr(toc_pkg::ADDR_TIMER_COUNT, 0);
        n = 2 + $urandom % 6;
        repeat (n) begin
            wr(toc_pkg::ADDR_PIN_SOURCE, 1);
            wr(toc_pkg::ADDR_PIN_SOURCE, 0);
        end
        wr(toc_pkg::ADDR_PIN_SOURCE, 1);
        rdr(toc_pkg::ADDR_PIN_SOURCE);
        chk(rd[0], 1);
        cyc(4);
        rdr(toc_pkg::ADDR_TIMER_COUNT);
        chk(rd, n + 1);
        wr(toc_pkg::ADDR_PORT_DATA, 32'h6);
        wr(toc_pkg::ADDR_TIMER_CONTROL, 32'hB);
        chk(osc, 1);
        rdr(toc_pkg::ADDR_PIN_SOURCE);
        chk(rd[0], 0);
        wr(toc_pkg::ADDR_PIN_SOURCE, 0);
        rdr(toc_pkg::ADDR_PORT_DATA);
        chk(rd[2:1], 0);
        wr(toc_pkg::ADDR_PORT_DIR, 32'h8);
        rdr(toc_pkg::ADDR_PORT_DATA);
        chk(rd[2:1], 3);
        wr(toc_pkg::ADDR_TIMER_COUNT, 0);
        n = xe;
        xtal_en <= 1'b1;
        cyc(200);
        xtal_en <= 1'b0;
        cyc(6);
        rdr(toc_pkg::ADDR_TIMER_COUNT);
        chk(rd, xe - n);
        wr(toc_pkg::ADDR_TIMER_CONTROL, 32'h1);
        chk({pin_oe[2:1], pin_out[2:1]}, 4'hF);
        rdr(toc_pkg::ADDR_PIN_SOURCE);
        chk(rd[0], 1);
        // Clock and crystal pins back to input before capturing
        wr(toc_pkg::ADDR_PORT_DIR, 32'hE);
        wr(toc_pkg::ADDR_ENABLE, 32'h4);
        for (int m = 0; m < 4; m++) begin
            mode = toc_pkg::CAP_FALL + m;
            cap_level <= (m == 0);
            cyc(6);
            // Unit off first so the prescaler starts clean
            wr(toc_pkg::ADDR_CAPTURE_CONTROL, 0);
            wr(toc_pkg::ADDR_CAPTURE_CONTROL, mode);
            wr(toc_pkg::ADDR_FLAG, 0);
            repeat (edges_needed(mode) - 1) pulse(m == 0);
            rdr(toc_pkg::ADDR_FLAG);
            chk(rd[2], 0);
            for (int k = 0; k < 2; k++) begin
                v = $urandom;
                wr(toc_pkg::ADDR_TIMER_CONTROL, 0);
                wr(toc_pkg::ADDR_TIMER_COUNT, v);
                repeat (k == 0 ? 1 : edges_needed(mode)) pulse(m == 0);
                rdr(toc_pkg::ADDR_CAPTURE_RESULT);
                chk(rd, {16'h0, v});
            end
            chk(irq, 1);
        end
        wr(toc_pkg::ADDR_ENABLE, 0);
        chk(irq, 0);
        rdr(toc_pkg::ADDR_FLAG);
        chk(rd[2], 1);
        wr(toc_pkg::ADDR_CAPTURE_CONTROL, toc_pkg::CAP_RISE);
        wr(toc_pkg::ADDR_PORT_DATA, 0);
        wr(toc_pkg::ADDR_PORT_DIR, 32'h6);
        wr(toc_pkg::ADDR_FLAG, 0);
        rdr(toc_pkg::ADDR_FLAG);
        chk(rd[2], 0);
        wr(toc_pkg::ADDR_PORT_DATA, 32'h8);
        cyc(6);
        rdr(toc_pkg::ADDR_FLAG);
        chk(rd[2], 1);
        wr(toc_pkg::ADDR_PORT_DIR, 32'hE);
        wr(toc_pkg::ADDR_CAPTURE_CONTROL, toc_pkg::CAP_RISE4);
        repeat (2) pulse(1'b0);
        wr(toc_pkg::ADDR_CAPTURE_CONTROL, 0);
        wr(toc_pkg::ADDR_CAPTURE_CONTROL, toc_pkg::CAP_RISE4);
        wr(toc_pkg::ADDR_FLAG, 0);
        repeat (3) pulse(1'b0);
        rdr(toc_pkg::ADDR_FLAG);
        chk(rd[2], 0);
        pulse(1'b0);
        rdr(toc_pkg::ADDR_FLAG);
        chk(rd[2], 1);
        finish_test();
    end
    task automatic pulse_ext();
        ext_level <= 1'b1;
        cyc(4);
        ext_level <= 1'b0;
        cyc(4);
    endtask
endmodule
